// ### rtl/edp_pkg.sv
// Constants, field layout and carrier types for the energy detect power control block.
// Assumes a serial management front end that presents 5-bit register addresses and 16-bit data.
// Behaviour
// - Energy detect mode runs only while control bit 15 is set; resets off.
// - With bit 14 set, power up once data events reach threshold bits 3:0.
// - With bit 13 set, power down when no energy is seen on the line.
// - Writing one to bit 12 toggles power state, ignoring thresholds; bit self-clears.
// - With bit 11 clear, send a burst of four data pulses per power up.
// - With bit 11 set, send a single data pulse per power up.
// - Bit 10 reads current power state; one is powered up.
// - Bit 9 sets when error threshold met, no action taken, clears on read.
// - Bit 8 sets when data events reach threshold, clears on read.
// - Bits 7:4 hold error threshold, read-write, reset 0001.
// - Bits 3:0 hold data threshold, read-write, reset 0001.
// - Both counters clear after about two seconds without a data event.
package edp_pkg;
   localparam logic [4:0] ADDR_CONTROL = 5'h1d;
   localparam int BIT_ENABLE = 15;
   localparam int BIT_AUTO_UP = 14;
   localparam int BIT_AUTO_DOWN = 13;
   localparam int BIT_MANUAL = 12;
   localparam int BIT_BURST_DIS = 11;
   localparam int BIT_POWER = 10;
   localparam int BIT_ERR_MET = 9;
   localparam int BIT_DATA_MET = 8;
   localparam int ERR_THR_LSB = 4;
   localparam int DATA_THR_LSB = 0;
   localparam int THR_W = 4;
   localparam logic [3:0] THR_RESET = 4'h1;
   localparam logic [2:0] BURST_PULSES = 3'h4;
   localparam logic [2:0] SINGLE_PULSES = 3'h1;
   localparam longint CLK_HZ = 100000000;
   localparam longint IDLE_TIMEOUT_S = 2;
   localparam longint IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_S * CLK_HZ;
   localparam int PULSE_GAP_NS = 1000;
   localparam int PULSE_GAP_CYC = (PULSE_GAP_NS + 9) / 10;

   typedef struct packed {
      logic enable;
      logic auto_up;
      logic auto_down;
      logic burst_disable;
      logic [3:0] error_event_threshold;
      logic [3:0] data_event_threshold;
   } edp_cfg_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [15:0] wdata;
   } edp_req_t;
endpackage

// ### rtl/edp_counter.sv
// Saturating event counter with threshold compare and idle clear.
// Assumes events are single-cycle pulses in the clk domain.
`timescale 1ns/1ps
module edp_counter #(
   parameter int W = 4
) (
   input wire logic clk, // System clock
   input wire logic resetn, // Synchronous reset, active low
   input wire logic event_in, // One-cycle event
   input wire logic clear, // Restart count
   input wire logic [W-1:0] threshold, // Compare level
   output logic met // Count at or above threshold and above zero
);
   typedef struct packed {
      logic [W-1:0] count;
   } edp_cnt_state_t;
   edp_cnt_state_t state, next_state;

   always_comb begin
      next_state = state;
      if (clear) begin
         next_state.count = '0;
      end else if (event_in && state.count != {W{1'b1}}) begin
         next_state.count = state.count + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign met = (state.count >= threshold) && (threshold != '0 || state.count != '0);
endmodule

// ### rtl/edp_pulser.sv
// Emits energy detect data pulses spaced by a gap, on request.
// Assumes start is a one-cycle pulse; a start while busy is ignored.
`timescale 1ns/1ps
module edp_pulser #(
   parameter int GAP = edp_pkg::PULSE_GAP_CYC
) (
   input wire logic clk, // System clock
   input wire logic resetn, // Synchronous reset, active low
   input wire logic start, // Begin a pulse sequence
   input wire logic [2:0] pulses, // Number of pulses to send
   output logic pulse // One-cycle line pulse request
);
   typedef struct packed {
      logic [2:0] left;
      logic [15:0] gap;
      logic pulse;
   } edp_pul_state_t;
   edp_pul_state_t state, next_state;

   always_comb begin
      next_state = state;
      next_state.pulse = 1'b0;
      if (state.left == 3'h0) begin
         if (start) begin
            next_state.left = pulses;
            next_state.gap = '0;
         end
      end else if (state.gap != 16'h0) begin
         next_state.gap = state.gap - 16'h1;
      end else begin
         next_state.pulse = 1'b1;
         next_state.left = state.left - 3'h1;
         next_state.gap = 16'(GAP);
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign pulse = state.pulse;
endmodule

// ### rtl/edp_power_control.sv
// Energy detect power control: control register, event counting and power state.
// Assumes the management front end gives one-cycle read and write strobes
// and that energy and event inputs come from the analog receiver, unsynchronised.
`timescale 1ns/1ps
module edp_power_control #(
   parameter longint IDLE_CYCLES = edp_pkg::IDLE_TIMEOUT_CYC
) (
   input wire logic clk, // System clock, 100 MHz
   input wire logic resetn, // Synchronous reset, active low
   input wire edp_pkg::edp_req_t req, // Management register request
   output logic [15:0] rdata, // Read data, valid cycle after rd
   output logic rvalid, // Read data strobe
   input wire logic energy_present, // Line energy level, async
   input wire logic data_event, // Data event level, async
   input wire logic error_event, // Error event level, async
   output logic line_power_state, // Line circuitry powered up
   output logic power_up_start, // Pulse: begin power up sequence
   output logic power_down_start, // Pulse: begin power down sequence
   output logic detect_pulse // Pulse: send one energy detect data pulse
);
   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic [1:0] energy_sync;
      logic [2:0] data_sync;
      logic [2:0] error_sync;
      edp_pkg::edp_cfg_t cfg;
      logic manual_pending;
      logic power;
      logic err_met;
      logic data_met;
      logic [31:0] idle;
      logic [15:0] rdata;
      logic rvalid;
      logic up_pulse;
      logic down_pulse;
   } edp_state_t;
   edp_state_t state, next_state;

   logic data_rise, error_rise, energy_now, idle_clear;
   logic data_hit, error_hit, is_ctrl, do_up, do_down, burst_pulse;
   logic [15:0] ctrl_view;

   // Second flop of the data and error synchronisers feeds edge detection, the first never does
   assign energy_now = state.energy_sync[1];
   assign data_rise = state.data_sync[1] & ~state.data_sync[2];
   assign error_rise = state.error_sync[1] & ~state.error_sync[2];
   assign idle_clear = (state.idle >= 32'(IDLE_CYCLES - 1)) | ~state.cfg.enable;
   assign is_ctrl = req.addr == edp_pkg::ADDR_CONTROL;

   edp_counter #(.W(edp_pkg::THR_W)) u_data_cnt (
      .clk(clk),
      .resetn(resetn),
      .event_in(data_rise & state.cfg.enable),
      .clear(idle_clear),
      .threshold(state.cfg.data_event_threshold),
      .met(data_hit)
   );

   edp_counter #(.W(edp_pkg::THR_W)) u_err_cnt (
      .clk(clk),
      .resetn(resetn),
      .event_in(error_rise & state.cfg.enable),
      .clear(idle_clear),
      .threshold(state.cfg.error_event_threshold),
      .met(error_hit)
   );

   // Pulse count chosen from burst-disable at the moment of power up
   edp_pulser u_pulser (
      .clk(clk),
      .resetn(resetn),
      .start(state.up_pulse),
      .pulses(state.cfg.burst_disable ? edp_pkg::SINGLE_PULSES : edp_pkg::BURST_PULSES),
      .pulse(burst_pulse)
   );

   always_comb begin
      ctrl_view = '0;
      ctrl_view[edp_pkg::BIT_ENABLE] = state.cfg.enable;
      ctrl_view[edp_pkg::BIT_AUTO_UP] = state.cfg.auto_up;
      ctrl_view[edp_pkg::BIT_AUTO_DOWN] = state.cfg.auto_down;
      ctrl_view[edp_pkg::BIT_MANUAL] = state.manual_pending;
      ctrl_view[edp_pkg::BIT_BURST_DIS] = state.cfg.burst_disable;
      ctrl_view[edp_pkg::BIT_POWER] = state.power;
      ctrl_view[edp_pkg::BIT_ERR_MET] = state.err_met;
      ctrl_view[edp_pkg::BIT_DATA_MET] = state.data_met;
      ctrl_view[edp_pkg::ERR_THR_LSB +: edp_pkg::THR_W] = state.cfg.error_event_threshold;
      ctrl_view[edp_pkg::DATA_THR_LSB +: edp_pkg::THR_W] = state.cfg.data_event_threshold;
   end

   // ==========================================================
   // Power decisions
   // ==========================================================
   // Manual toggle overrides automatic action in the same cycle
   always_comb begin
      do_up = 1'b0;
      do_down = 1'b0;
      if (state.cfg.enable) begin
         if (state.manual_pending) begin
            do_up = ~state.power;
            do_down = state.power;
         end else if (!state.power) begin
            do_up = state.cfg.auto_up & data_hit;
         end else begin
            do_down = state.cfg.auto_down & ~energy_now;
         end
      end
   end

   always_comb begin
      next_state = state;
      next_state.energy_sync = {state.energy_sync[0], energy_present};
      next_state.data_sync = {state.data_sync[1:0], data_event};
      next_state.error_sync = {state.error_sync[1:0], error_event};
      next_state.rvalid = 1'b0;
      next_state.up_pulse = do_up;
      next_state.down_pulse = do_down;

      // Idle timer restarts on every data event
      if (data_rise || idle_clear) begin
         next_state.idle = '0;
      end else begin
         next_state.idle = state.idle + 32'h1;
      end

      if (do_up) begin
         next_state.power = 1'b1;
      end else if (do_down) begin
         next_state.power = 1'b0;
      end
      // Manual bit clears once acted on, or at once when mode is off
      if (state.manual_pending) begin
         next_state.manual_pending = 1'b0;
      end

      // Reads clear the met flags, but a set in the same cycle wins
      if (req.rd && is_ctrl) begin
         next_state.rdata = ctrl_view;
         next_state.rvalid = 1'b1;
         next_state.err_met = 1'b0;
         next_state.data_met = 1'b0;
      end else if (req.rd) begin
         next_state.rdata = '0;
         next_state.rvalid = 1'b1;
      end
      if (state.cfg.enable && error_hit) begin
         next_state.err_met = 1'b1;
      end
      if (state.cfg.enable && data_hit) begin
         next_state.data_met = 1'b1;
      end

      if (req.wr && is_ctrl) begin
         next_state.cfg.enable = req.wdata[edp_pkg::BIT_ENABLE];
         next_state.cfg.auto_up = req.wdata[edp_pkg::BIT_AUTO_UP];
         next_state.cfg.auto_down = req.wdata[edp_pkg::BIT_AUTO_DOWN];
         next_state.cfg.burst_disable = req.wdata[edp_pkg::BIT_BURST_DIS];
         next_state.cfg.error_event_threshold = req.wdata[edp_pkg::ERR_THR_LSB +: edp_pkg::THR_W];
         next_state.cfg.data_event_threshold = req.wdata[edp_pkg::DATA_THR_LSB +: edp_pkg::THR_W];
         if (req.wdata[edp_pkg::BIT_MANUAL]) begin
            next_state.manual_pending = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= '0;
         state.cfg.auto_up <= 1'b1;
         state.cfg.auto_down <= 1'b1;
         state.cfg.error_event_threshold <= edp_pkg::THR_RESET;
         state.cfg.data_event_threshold <= edp_pkg::THR_RESET;
      end else begin
         state <= next_state;
      end
   end

   // Pulse output is registered inside the pulser
   assign rdata = state.rdata;
   assign rvalid = state.rvalid;
   assign line_power_state = state.power;
   assign power_up_start = state.up_pulse;
   assign power_down_start = state.down_pulse;
   assign detect_pulse = burst_pulse;
endmodule

// ### sim/edp_checker.sv
// Port assertions for the energy detect power control block.
// Assumes it is bound to the top module; config bits are mirrored from register writes.
`timescale 1ns/1ps
module edp_checker #(
   parameter longint IDLE_CYCLES = 50
) (
   input wire logic clk, // Clock
   input wire logic resetn, // Sync reset, low
   input wire edp_pkg::edp_req_t req, // Register request
   input wire logic [15:0] rdata, // Read data
   input wire logic rvalid, // Read strobe
   input wire logic energy_present, // Line energy
   input wire logic line_power_state, // Powered up
   input wire logic power_up_start, // Up pulse
   input wire logic power_down_start, // Down pulse
   input wire logic detect_pulse // Data pulse
);
   localparam int GAP1 = edp_pkg::PULSE_GAP_CYC + 1;
   logic [15:0] cfg;
   wire logic hit = req.wr && req.addr == edp_pkg::ADDR_CONTROL;
   always_ff @(posedge clk) begin
      if (!resetn) cfg <= 16'h6011;
      else if (hit) cfg <= req.wdata;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // ======
   // Register path
   property p_rvalid; req.rd |=> rvalid; endproperty
   a_rvalid: assert property (p_rvalid) else $error("read not answered");
   property p_state;
      rvalid && $past(req.addr) == edp_pkg::ADDR_CONTROL |-> rdata[10] == $past(line_power_state);
   endproperty
   a_state: assert property (p_state) else $error("power bit differs from state");
   property p_unmapped; rvalid && $past(req.addr) != edp_pkg::ADDR_CONTROL |-> rdata == 16'h0000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   // ======
   // Power sequencing
   property p_manual; hit && req.wdata[15] && req.wdata[12] |-> ##[1:3] (power_up_start || power_down_start); endproperty
   a_manual: assert property (p_manual) else $error("manual toggle lost");
   sequence s_burst;
      detect_pulse ##GAP1 detect_pulse ##GAP1 detect_pulse ##GAP1 detect_pulse;
   endsequence
   sequence s_single;
      detect_pulse ##1 (!detect_pulse) [*8];
   endsequence
   property p_burst; power_up_start && !cfg[11] |-> ##2 s_burst; endproperty
   a_burst: assert property (p_burst) else $error("burst of four missing");
   property p_single; power_up_start && cfg[11] |-> ##2 s_single; endproperty
   a_single: assert property (p_single) else $error("single pulse wrong");
   // Energy passes a two-flop synchroniser, hence the slack
   property p_down;
      line_power_state && cfg[15] && cfg[13] && !energy_present && !power_down_start && !power_up_start
         |-> ##[1:6] power_down_start;
   endproperty
   a_down: assert property (p_down) else $error("no power down without energy");
   property p_off; (!cfg[15]) [*4] |-> !power_up_start && !power_down_start; endproperty
   a_off: assert property (p_off) else $error("power change while disabled");
endmodule

// ### sim/edp_line_model.sv
// Twisted-pair line partner: energy level and data or error event levels.
// Assumes the bench calls its tasks just after a falling clock edge.
`timescale 1ns/1ps
module edp_line_model (
   input wire logic clk, // Clock
   output logic energy_present, // Energy on line
   output logic data_event, // Data event level
   output logic error_event // Error event level
);
   initial begin
      energy_present = 1'b0;
      data_event = 1'b0;
      error_event = 1'b0;
   end
   task automatic line(input bit e);
      energy_present = e;
   endtask
   // Levels stay four cycles each way so the receiver synchroniser never drops an edge
   task automatic send(input bit err, input int n);
      repeat (n) begin
         if (err) error_event = 1'b1;
         else data_event = 1'b1;
         repeat (4) @(negedge clk);
         error_event = 1'b0;
         data_event = 1'b0;
         repeat (4) @(negedge clk);
      end
   endtask
endmodule

// ### sim/tb.sv
// Self-checking bench for the energy detect power control block.
// Assumes the line model and checker files are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; $display("unexpected %0t %h", $time, a); end end
module tb;
   localparam logic [4:0] A = edp_pkg::ADDR_CONTROL;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   edp_pkg::edp_req_t req = '0;
   logic [15:0] rdata;
   logic rvalid, energy_present, data_event, error_event;
   logic line_power_state, power_up_start, power_down_start, detect_pulse;
   int err_total = 0;
   int comparisons = 0;
   int pulses = 0;
   always #5 clk = ~clk;
   edp_power_control #(.IDLE_CYCLES(50)) edp_power_control_i (.clk(clk), .resetn(resetn), .req(req),
      .rdata(rdata), .rvalid(rvalid), .energy_present(energy_present), .data_event(data_event),
      .error_event(error_event), .line_power_state(line_power_state), .power_up_start(power_up_start),
      .power_down_start(power_down_start), .detect_pulse(detect_pulse));
   edp_line_model edp_line_model_i (.clk(clk), .energy_present(energy_present), .data_event(data_event),
      .error_event(error_event));
   // Counted away from the launching edge so the pulse is never raced
   always @(negedge clk) if (detect_pulse === 1'b1) pulses++;
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge clk);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge clk);
      req.wr = 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] exp, input logic [15:0] m);
      @(negedge clk);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge clk);
      req.rd = 1'b0;
      `CHK(rvalid, 1'b1)
      `CHK(rdata & m, exp & m)
   endtask
   task automatic settle(input logic lvl);
      for (int i = 0; i < 100 && line_power_state !== lvl; i++) @(negedge clk);
      `CHK(line_power_state, lvl)
   endtask
   task automatic conclude;
      if (err_total == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      conclude();
   end
   initial begin
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      rd(A, 16'h6011, 16'hffff);
      wr(5'h1c, 16'hffff);
      rd(5'h1c, 16'h0000, 16'hffff);
      wr(A, 16'he023);
      rd(A, 16'he023, 16'hffff);
      edp_line_model_i.send(1, 2);
      rd(A, 16'h0200, 16'h0700);
      repeat (60) @(negedge clk);
      // Flag is set again while the count sits at threshold, until the idle clear
      rd(A, 16'h0200, 16'h0200);
      rd(A, 16'h0000, 16'h0200);
      edp_line_model_i.line(1);
      edp_line_model_i.send(0, 2);
      repeat (60) @(negedge clk);
      edp_line_model_i.send(0, 2);
      rd(A, 16'h0000, 16'h0500);
      edp_line_model_i.send(0, 1);
      settle(1);
      rd(A, 16'h0500, 16'h0500);
      repeat (400) @(negedge clk);
      `CHK(pulses, 4)
      edp_line_model_i.line(0);
      settle(0);
      edp_line_model_i.line(1);
      wr(A, 16'hf823); // Manual up, with burst disable set for a single pulse
      settle(1);
      rd(A, 16'h0c00, 16'h1c00);
      repeat (400) @(negedge clk);
      `CHK(pulses, 5)
      wr(A, 16'hf823);
      settle(0);
      wr(A, 16'h6023);
      edp_line_model_i.send(0, 4);
      rd(A, 16'h6023, 16'hfbff);
      `CHK(pulses, 5)
      conclude();
   end
endmodule
bind edp_power_control edp_checker #(.IDLE_CYCLES(IDLE_CYCLES)) edp_checker_i (.clk(clk), .resetn(resetn),
   .req(req), .rdata(rdata), .rvalid(rvalid), .energy_present(energy_present),
   .line_power_state(line_power_state), .power_up_start(power_up_start),
   .power_down_start(power_down_start), .detect_pulse(detect_pulse));
